// file: src/pin_sync.sv
// Purpose: Two flop synchroniser for a vector of pin levels
// Assumes: Inputs are asynchronous to ref_clk
// Notes: First stage is read only by the second

`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // Two stages keep metastability away from the read path
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // pin_sync

`default_nettype wire

// file: src/port_latch_steer.sv
// Purpose: GPIO ports with direction, latch, pin read, analog select and function steering
// Assumes: Wishbone classic slave on ref_clk; pins sampled through two flops
// Notes: Ports A and B always exist; port C exists when NUM_PORTS is 3
//
// The Wishbone register port and the register addresses are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module port_latch_steer
    import port_steer_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Pads
    input wire logic [NUM_PORTS*PORT_W-1:0] pad_in,
    output logic [NUM_PORTS*PORT_W-1:0] pad_out,
    output logic [NUM_PORTS*PORT_W-1:0] pad_oe,
    output logic [NUM_PORTS*PORT_W-1:0] pad_ana,
    // Peripheral side
    input wire periph_outs_s pout,
    input wire periph_in_en_s pin_en,
    output periph_ins_s pins
);

    localparam int NB = NUM_PORTS * PORT_W;

    logic [PORT_W-1:0] dir_r [NUM_PORTS];
    logic [PORT_W-1:0] lat_r [NUM_PORTS];
    logic [PORT_W-1:0] ana_r [NUM_PORTS];
    logic [7:0] steer_r;
    logic [NB-1:0] pin_sync_q;
    logic [NB-1:0] pin_dig;
    logic [2*PORT_W-1:0] ovr_en;
    logic [2*PORT_W-1:0] ovr_val;
    logic [2*PORT_W-1:0] in_claim;
    periph_ins_s pins_nxt;
    logic [NB-1:0] out_nxt;
    logic [NB-1:0] oe_nxt;
    logic [NB-1:0] ana_flat;
    logic req;
    logic hit;
    logic [31:0] rd_nxt;
    logic [1:0] acc_port;
    logic [1:0] acc_kind;
    logic acc_port_reg;
    logic acc_steer;

    // Pin levels are asynchronous, so they pass two flops first
    pin_sync #(
        .W(NB)
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .d(pad_in),
        .q(pin_sync_q)
    );

    // Analog pins read zero on every digital path
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            ana_flat[p*PORT_W +: PORT_W] = ana_r[p];
            pin_dig[p*PORT_W +: PORT_W] = pin_sync_q[p*PORT_W +: PORT_W] & ~ana_r[p];
        end
    end

    steer_route u_route (
        .steer(steer_r),
        .pout(pout),
        .pin_en(pin_en),
        .pin_lvl(pin_dig[2*PORT_W-1:0]),
        .ovr_en(ovr_en),
        .ovr_val(ovr_val),
        .in_claim(in_claim),
        .pins(pins_nxt)
    );

    // Pad drive: peripheral override first, then an input claim releases the pin, else the latch under direction control
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            if (i < 2*PORT_W && ovr_en[i]) begin
                out_nxt[i] = ovr_val[i];
                oe_nxt[i] = 1'b1;
            end else if (i < 2*PORT_W && in_claim[i]) begin
                out_nxt[i] = 1'b0;
                oe_nxt[i] = 1'b0;
            end else begin
                out_nxt[i] = lat_r[i/PORT_W][i%PORT_W];
                oe_nxt[i] = ~dir_r[i/PORT_W][i%PORT_W];
            end
        end
    end

    // Registered pad and peripheral outputs; analog select does not gate output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_ana <= '1;
            pins <= '0;
        end else begin
            pad_out <= out_nxt;
            pad_oe <= oe_nxt;
            pad_ana <= ana_flat;
            pins <= pins_nxt;
        end
    end

    // Address decode
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign acc_port = wb_adr_i[5:4];
    assign acc_kind = wb_adr_i[3:2];
    assign acc_port_reg = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00)
        && (32'(acc_port) < NUM_PORTS);
    assign acc_steer = (wb_adr_i == STEER_OFF);
    assign hit = acc_port_reg | acc_steer;

    // Read mux: latch shows driven values, pin register shows pad levels
    always_comb begin
        rd_nxt = '0;
        if (acc_steer) begin
            rd_nxt[7:0] = steer_r;
        end else if (acc_port_reg) begin
            case (8'({acc_kind, 2'b00}))
                DIR_OFF: rd_nxt[7:0] = dir_r[acc_port];
                LAT_OFF: rd_nxt[7:0] = lat_r[acc_port];
                PIN_OFF: rd_nxt[7:0] = pin_dig[acc_port*PORT_W +: PORT_W];
                ANA_OFF: rd_nxt[7:0] = ana_r[acc_port];
                default: rd_nxt = '0;
            endcase
        end
    end

    // Bus answer one cycle after the request; unmapped addresses get err
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            wb_dat_o <= (req & hit & ~wb_we_i) ? rd_nxt : 32'h00000000;
        end
    end

    // Port registers; writing latch or pin register loads the same latch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dir_r[p] <= DIR_RST;
                lat_r[p] <= LAT_RST;
                ana_r[p] <= ANA_RST;
            end
        end else if (req && wb_we_i && acc_port_reg && wb_sel_i[0]) begin
            case (8'({acc_kind, 2'b00}))
                DIR_OFF: dir_r[acc_port] <= wb_dat_i[7:0];
                LAT_OFF: lat_r[acc_port] <= wb_dat_i[7:0];
                PIN_OFF: lat_r[acc_port] <= wb_dat_i[7:0];
                ANA_OFF: ana_r[acc_port] <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Steering register; it only reroutes overrides and the two input functions with their claims, directions stay as written
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            steer_r <= STEER_RST;
        end else if (req && wb_we_i && acc_steer && wb_sel_i[0]) begin
            steer_r <= wb_dat_i[7:0];
        end
    end

endmodule // port_latch_steer

`default_nettype wire

// file: src/port_steer_pkg.sv
// Purpose: Shared constants and carrier types for the port latch and pin steering block
// Assumes: Wishbone classic slave, 8-bit registers in the low byte of 32-bit words
// Notes: Byte offsets are word aligned

package port_steer_pkg;

    localparam int PORT_W = 8;
    localparam int NUM_PORTS_MAX = 3;

    // Register byte offsets: port n at PORT_STRIDE * n
    localparam logic [7:0] DIR_OFF = 8'h00;
    localparam logic [7:0] LAT_OFF = 8'h04;
    localparam logic [7:0] PIN_OFF = 8'h08;
    localparam logic [7:0] ANA_OFF = 8'h0C;
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [7:0] STEER_OFF = 8'h30;

    // Reset values
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] ANA_RST = 8'hFF;
    localparam logic [7:0] STEER_RST = 8'h00;

    // Steering field positions
    localparam int SEL_RECV = 7;
    localparam int SEL_SPI_OUT = 6;
    localparam int SEL_SPI_SS = 5;
    localparam int SEL_PWM2B = 4;
    localparam int SEL_CAP2A = 3;
    localparam int SEL_PWM1D = 2;
    localparam int SEL_PWM1C = 1;
    localparam int SEL_CAP1A = 0;

    // Port indices used by steering
    localparam int PA = 0;
    localparam int PB = 1;

    // One peripheral output function: value and drive enable
    typedef struct packed {
        logic val;
        logic en;
    } periph_out_s;

    // All movable output functions
    typedef struct packed {
        periph_out_s spi_out;
        periph_out_s pwm2b;
        periph_out_s cap2a;
        periph_out_s pwm1d;
        periph_out_s pwm1c;
        periph_out_s cap1a;
    } periph_outs_s;

    // Movable input functions and their enables
    typedef struct packed {
        logic recv_en;
        logic ss_en;
    } periph_in_en_s;

    typedef struct packed {
        logic uart_receive_data;
        logic spi1_slave_select;
    } periph_ins_s;

endpackage

// file: src/steer_route.sv
// Purpose: Route movable peripheral functions onto one of two pins
// Assumes: Steering bits come from the register file
// Notes: Purely combinational, output is registered by the top

`timescale 1ns/1ps
`default_nettype none

module steer_route
    import port_steer_pkg::*;
(
    // Control
    input wire logic [7:0] steer,
    input wire periph_outs_s pout,
    input wire periph_in_en_s pin_en,
    input wire logic [2*PORT_W-1:0] pin_lvl,
    // Override to ports A and B
    output logic [2*PORT_W-1:0] ovr_en,
    output logic [2*PORT_W-1:0] ovr_val,
    output logic [2*PORT_W-1:0] in_claim,
    output periph_ins_s pins
);

    function automatic int bidx(input int port, input int pin);
        return port * PORT_W + pin;
    endfunction

    // Place an output on the chosen pin only; the other keeps its port behaviour
    always_comb begin
        ovr_en = '0;
        ovr_val = '0;
        in_claim = '0;
        pins = '0;
        if (pout.spi_out.en) begin
            ovr_en[steer[SEL_SPI_OUT] ? bidx(PA, 6) : bidx(PB, 2)] = 1'b1;
            ovr_val[steer[SEL_SPI_OUT] ? bidx(PA, 6) : bidx(PB, 2)] = pout.spi_out.val;
        end
        if (pout.cap1a.en) begin
            ovr_en[steer[SEL_CAP1A] ? bidx(PB, 0) : bidx(PB, 3)] = 1'b1;
            ovr_val[steer[SEL_CAP1A] ? bidx(PB, 0) : bidx(PB, 3)] = pout.cap1a.val;
        end
        if (pout.pwm2b.en) begin
            ovr_en[steer[SEL_PWM2B] ? bidx(PA, 6) : bidx(PB, 7)] = 1'b1;
            ovr_val[steer[SEL_PWM2B] ? bidx(PA, 6) : bidx(PB, 7)] = pout.pwm2b.val;
        end
        if (pout.cap2a.en) begin
            ovr_en[steer[SEL_CAP2A] ? bidx(PA, 7) : bidx(PB, 6)] = 1'b1;
            ovr_val[steer[SEL_CAP2A] ? bidx(PA, 7) : bidx(PB, 6)] = pout.cap2a.val;
        end
        if (pout.pwm1d.en) begin
            ovr_en[steer[SEL_PWM1D] ? bidx(PA, 6) : bidx(PB, 7)] = 1'b1;
            ovr_val[steer[SEL_PWM1D] ? bidx(PA, 6) : bidx(PB, 7)] = pout.pwm1d.val;
        end
        if (pout.pwm1c.en) begin
            ovr_en[steer[SEL_PWM1C] ? bidx(PA, 7) : bidx(PB, 6)] = 1'b1;
            ovr_val[steer[SEL_PWM1C] ? bidx(PA, 7) : bidx(PB, 6)] = pout.pwm1c.val;
        end
        // Inputs come from the selected pin, which is released as a tristate input while its enable is set and no output override takes that pin
        if (pin_en.recv_en) begin
            in_claim[steer[SEL_RECV] ? bidx(PB, 2) : bidx(PB, 1)] = 1'b1;
        end
        if (pin_en.ss_en) begin
            in_claim[steer[SEL_SPI_SS] ? bidx(PA, 5) : bidx(PB, 5)] = 1'b1;
        end
        pins.uart_receive_data = steer[SEL_RECV] ? pin_lvl[bidx(PB, 2)] : pin_lvl[bidx(PB, 1)];
        pins.spi1_slave_select = steer[SEL_SPI_SS] ? pin_lvl[bidx(PA, 5)] : pin_lvl[bidx(PB, 5)];
    end

endmodule // steer_route

`default_nettype wire

// file: test/pad_partner.sv
// Purpose: External pin drivers seen from the pads
// Assumes: Far side drives every pin the block leaves undriven
// Notes: No pull-ups modelled, so no released level exists
`timescale 1ns/1ps
`default_nettype none
module pad_partner #(
    parameter int NB = 24
) (
    // Block side
    input wire logic [NB-1:0] pad_out,
    input wire logic [NB-1:0] pad_oe,
    // Far side drive and resolved level
    input wire logic [NB-1:0] ext_lvl,
    output logic [NB-1:0] pad_in
);
    // A driven pin shows the block's value, the rest the far side's
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule // pad_partner
`default_nettype wire

// file: test/port_latch_steer_monitor.sv
// Purpose: Bus and steering properties of the port block
// Assumes: Only top-level ports are visible
// Notes: Steering bits are unseen, so either candidate pin is accepted
`timescale 1ns/1ps
`default_nettype none
module port_latch_steer_monitor
    import port_steer_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Pads and peripherals
    input wire logic [NUM_PORTS*PORT_W-1:0] pad_oe,
    input wire periph_outs_s pout
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    logic taken;
    logic mapped;
    // Port C space only exists on the large variant
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped = wb_adr_i[1:0] == 2'b00 && wb_adr_i <= STEER_OFF
        && (NUM_PORTS == 3 || wb_adr_i < 8'h20 || wb_adr_i == STEER_OFF);
    ack_mapped_a: assert property (taken && mapped |=> wb_ack_o && !wb_err_o)
        else $error("Mapped access not acknowledged");
    err_unmapped_a: assert property (taken && wb_adr_i > STEER_OFF |=> wb_err_o && !wb_ack_o)
        else $error("Unmapped access not refused");
    ans_single_a: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("Answer longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("Read data outside answer");
    dat_upper_a: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("Upper read lanes not zero");
    spi_oe_a: assert property (pout.spi_out.en |=> pad_oe[10] || pad_oe[6])
        else $error("Serial out pin not driven");
    cap1_oe_a: assert property (pout.cap1a.en |=> pad_oe[11] || pad_oe[8])
        else $error("Capture one pin not driven");
    cap2_oe_a: assert property (pout.cap2a.en |=> pad_oe[14] || pad_oe[7])
        else $error("Capture two pin not driven");
endmodule // port_latch_steer_monitor
bind port_latch_steer port_latch_steer_monitor #(.NUM_PORTS(NUM_PORTS)) mon_inst (
    .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pad_oe(pad_oe), .pout(pout));
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the port latch and steering block
// Assumes: Large variant, far side drives all undriven pins
// Notes: Random data from a fixed seed plus steering corner cases
`timescale 1ns/1ps
`default_nettype none
module tb;
    import port_steer_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic bus_err;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [23:0] ext = 24'h000000;
    periph_outs_s pout = '0;
    periph_in_en_s pin_en = '0;
    periph_ins_s pins;
    wire logic [31:0] rdat;
    wire logic ack;
    wire logic err;
    wire logic [23:0] pad_in;
    wire logic [23:0] pad_out;
    wire logic [23:0] pad_oe;
    wire logic [23:0] pad_ana;
    int err_count = 0;
    int samples_checked = 0;
    localparam int SB[6] = '{SEL_CAP1A, SEL_PWM1C, SEL_PWM1D, SEL_CAP2A, SEL_PWM2B, SEL_SPI_OUT};
    localparam int P0[6] = '{11, 14, 15, 14, 15, 10};
    localparam int P1[6] = '{8, 7, 6, 7, 6, 6};
    always #25 ref_clk = ~ref_clk;
    port_latch_steer #(.NUM_PORTS(3)) port_latch_steer_inst (
        .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_ana(pad_ana), .pout(pout), .pin_en(pin_en), .pins(pins));
    pad_partner #(.NB(24)) pad_partner_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));
    function automatic logic [7:0] ad(int p, logic [7:0] o);
        return 8'(p) * PORT_STRIDE + o;
    endfunction
    // Pin read: driven pins give the latch, inputs the far side, analog pins zero
    function automatic logic [7:0] pin_exp(logic [7:0] d, l, e, a);
        return ((~d & l) | (d & e)) & ~a;
    endfunction
    function automatic int sel_pin(int k, int b);
        return b ? P1[k] : P0[k];
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // One classic cycle, held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        q = rdat[7:0];
        bus_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        test_done();
    end
    initial begin
        logic [7:0] q, d, l, a;
        logic v;
        int p, i, k, b, n;
        void'($urandom(32'h5A88223A));
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        // Reset values, port C present, unmapped space refused
        for (p = 0; p < 3; p++) begin
            wb(0, ad(p, DIR_OFF), 8'h00, q);
            chk("dir reset", DIR_RST, q);
            wb(0, ad(p, LAT_OFF), 8'h00, q);
            chk("latch reset", LAT_RST, q);
            wb(0, ad(p, ANA_OFF), 8'h00, q);
            chk("analog reset", ANA_RST, q);
            chk("port present", 8'h00, bus_err);
        end
        wb(0, STEER_OFF, 8'h00, q);
        chk("steer reset", STEER_RST, q);
        wb(0, 8'h40, 8'h00, q);
        chk("unmapped err", 8'h01, bus_err);
        // Random GPIO traffic; odd passes write through the pin register
        for (i = 0; i < 8; i++) begin
            p = $urandom % 3;
            d = 8'($urandom);
            l = 8'($urandom);
            a = 8'($urandom);
            ext <= 24'($urandom);
            wb(1, ad(p, ANA_OFF), 8'h00, q);
            wb(1, ad(p, DIR_OFF), d, q);
            wb(1, ad(p, i % 2 ? PIN_OFF : LAT_OFF), l, q);
            repeat (4) @(posedge ref_clk);
            chk("pad oe", ~d, pad_oe[p*8 +: 8]);
            chk("pad out", l & ~d, pad_out[p*8 +: 8] & ~d);
            wb(0, ad(p, LAT_OFF), 8'h00, q);
            chk("latch read", l, q);
            wb(0, ad(p, PIN_OFF), 8'h00, q);
            chk("pin read", pin_exp(d, l, ext[p*8 +: 8], 8'h00), q);
            wb(1, ad(p, ANA_OFF), a, q);
            repeat (4) @(posedge ref_clk);
            wb(0, ad(p, PIN_OFF), 8'h00, q);
            chk("analog read", pin_exp(d, l, ext[p*8 +: 8], a), q);
            chk("analog oe", ~d, pad_oe[p*8 +: 8]);
            chk("analog pads", a, pad_ana[p*8 +: 8]);
        end
        // Ports A and B as inputs: only a peripheral may drive
        for (p = 0; p < 2; p++) begin
            wb(1, ad(p, DIR_OFF), 8'hFF, q);
            wb(1, ad(p, ANA_OFF), 8'h00, q);
        end
        for (k = 0; k < 6; k++) begin
            for (b = 0; b < 2; b++) begin
                wb(1, STEER_OFF, 8'(b) << SB[k], q);
                wb(0, STEER_OFF, 8'h00, q);
                chk("steer read", 8'(b) << SB[k], q);
                v = 1'($urandom);
                pout <= periph_outs_s'(12'(v ? 3 : 1) << (2 * k));
                repeat (2) @(posedge ref_clk);
                chk("steered oe", 8'h01, pad_oe[sel_pin(k, b)]);
                chk("steered val", 8'(v), pad_out[sel_pin(k, b)]);
                chk("other pin", 8'h00, pad_oe[sel_pin(k, 1 - b)]);
                pout <= '0;
            end
        end
        wb(0, DIR_OFF, 8'h00, q);
        chk("dir kept", 8'hFF, q);
        // Input functions claim a driven pin and read it through steering
        wb(1, ad(1, DIR_OFF), 8'h00, q);
        wb(1, ad(0, DIR_OFF), 8'h00, q);
        for (k = 0; k < 2; k++) begin
            for (b = 0; b < 2; b++) begin
                wb(1, STEER_OFF, 8'(b) << (k ? SEL_SPI_SS : SEL_RECV), q);
                pin_en <= k ? 2'b01 : 2'b10;
                v = 1'($urandom);
                n = k ? (b ? 5 : 13) : (b ? 10 : 9);
                ext[n] <= v;
                repeat (5) @(posedge ref_clk);
                chk("claim oe", 8'h00, pad_oe[n]);
                chk("steered in", 8'(v), k ? pins.spi1_slave_select : pins.uart_receive_data);
                pin_en <= '0;
            end
        end
        test_done();
    end
endmodule // tb
`default_nettype wire
